// [rtl/pcd_pkg.sv]
// Package of constants and types for the PHY control and diagnostics block
package pcd_pkg;

  // ----------------------------------------------------------------------------
  // Register addresses on the serial management interface
  // ----------------------------------------------------------------------------
  localparam logic [4:0] REG_BASIC   = 5'h00;
  localparam logic [4:0] REG_SPECIAL = 5'h16;
  localparam logic [4:0] REG_IRQ     = 5'h1B;
  localparam logic [4:0] REG_CABLE   = 5'h1D;
  localparam logic [4:0] REG_CTRL2   = 5'h1F;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int BC_LOCAL_LOOP  = 14;
  localparam int BC_SPEED_100   = 13;
  localparam int BC_ANEG_EN     = 12;
  localparam int BC_FULL_DUPLEX = 8;
  localparam int SC_CHAIN_TEST  = 5;
  localparam int C2_PAIR_FORCE  = 14;
  localparam int C2_AUTOX_DIS   = 13;
  localparam int C2_IRQ_POL     = 9;
  localparam int C2_REMOTE_LOOP = 2;
  localparam int CT_START       = 15;
  localparam int IRQ_EN_LSB     = 8;

  // ----------------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------------
  localparam logic [15:0] BASIC_RST   = 16'h0000;
  localparam logic [15:0] SPECIAL_RST = 16'h0000;
  localparam logic [7:0]  IRQ_EN_RST  = 8'h00;
  localparam logic [15:0] CTRL2_RST   = 16'h0000;

  // ----------------------------------------------------------------------------
  // Cable test result codes
  // ----------------------------------------------------------------------------
  localparam logic [1:0] CT_NORMAL  = 2'h0;
  localparam logic [1:0] CT_OPEN    = 2'h1;
  localparam logic [1:0] CT_SHORT   = 2'h2;
  localparam logic [1:0] CT_INVALID = 2'h3;

  // ----------------------------------------------------------------------------
  // Management frame layout
  // ----------------------------------------------------------------------------
  localparam logic [5:0] PRE_ONES  = 6'h20;
  localparam logic [3:0] HDR_BITS  = 4'hC;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [4:0] PHY_BCAST = 5'h00;

  // ----------------------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------------------
  localparam int          CLK_MHZ        = 250;
  localparam int          QUIET_WAIT_NS  = 10000;
  localparam int          QUIET_WAIT_INT = (QUIET_WAIT_NS * CLK_MHZ) / 1000;
  localparam logic [11:0] QUIET_WAIT_CYC = QUIET_WAIT_INT[11:0];
  localparam int          CHAIN_LEN      = 19;

  typedef enum logic [2:0] {M_PRE, M_START, M_HDR, M_TA, M_DATA} pcd_mdio_e;
  typedef enum logic [1:0] {C_IDLE, C_QUIET, C_MEAS} pcd_cable_e;

endpackage : pcd_pkg

// [rtl/pcd_top.sv]
// Control, interrupt, crossover, loopback, cable test and chain test logic of the PHY
`timescale 1ns/10ps

// Function
// - Interrupt register high byte enables each condition onto the interrupt output.
// - Interrupt register low byte holds sticky flags of conditions that occurred.
// - Reading the interrupt register clears all of its status flags.
// - Control-2 bit 9 picks interrupt output polarity; active low after reset.
// - Automatic crossover on after reset; control-2 bit 13 set disables it.
// - Automatic crossover matches own pairs to the partner's detected pairs.
// - With crossover disabled, control-2 bit 14 forces MDI or MDI-X.
// - Basic control bit 14 selects local loopback at 10 or 100 full duplex.
// - Control-2 bit 2 enables remote loopback, only at 100BASE-TX full duplex.
// - Cable register bit 15 starts test, self-clears on completion; software polls.
// - Result field: 00 normal, 01 open, 10 short, 11 invalid.
// - If the partner cannot be silenced, skip measurement and report invalid.
// - Nine-bit fault distance in low bits; count times 0.38 gives meters.
// - In chain test, each pin feeds a NAND chain; carrier sense outputs it.
// - Chain test entered by strap or special control bit 5; TXER pulled up.
// - Chain order MDIO, MDC, RXD3..0, RXDV, RXC, RXER, IRQ, TXC, TXEN, TXD0..3, LEDs, COL.
// - Each successive input driven low toggles the chain output in alternation.
// - Registers reached over serial management, 5-bit addresses, 16-bit data.
module pcd_top #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        mgmt_clk,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [7:0]  irq_events,
  output logic             irq_out,
  input  wire logic        partner_is_mdi,
  output logic             mdix_sel,
  input  wire logic        link_100_full,
  output logic             local_loop,
  output logic             remote_loop,
  output logic             speed_100,
  output logic             aneg_en,
  output logic             full_duplex,
  output logic             tdr_start,
  input  wire logic        partner_quiet,
  input  wire logic        tdr_done,
  input  wire logic [1:0]  tdr_result,
  input  wire logic [8:0]  tdr_dist,
  input  wire logic        chain_strap_b,
  input  wire logic [18:0] chain_pad_in,
  input  wire logic        crs_core,
  output logic             crs_out
);

  // ----------------------------------------------------------------------------
  // Management clock domain: frame decode and shifting
  // ----------------------------------------------------------------------------
  logic [1:0]       mrst_sync_q;
  logic             mrst_b;
  pcd_pkg::pcd_mdio_e m_state_q;
  logic [5:0]       ones_q;
  logic [4:0]       bit_cnt_q;
  logic [10:0]      hdr_q;
  logic [15:0]      shift_q;
  logic             is_read_q;
  logic             req_tgl_q;
  logic [4:0]       req_addr_q;
  logic             req_we_q;
  logic [15:0]      req_wdata_q;
  logic [15:0]      rdata_q;
  logic             hdr_match;

  // Reset reaches this domain through its own synchroniser; two idle edges before the preamble flush it
  always_ff @(posedge mgmt_clk)
  begin
    mrst_sync_q <= {mrst_sync_q[0], rst_b};
  end
  assign mrst_b = mrst_sync_q[1];

  assign hdr_match = ({hdr_q[8:0], mdio_in} >> 5) == {5'h00, PHY_ADDR}
                  || ({hdr_q[8:0], mdio_in} >> 5) == {5'h00, pcd_pkg::PHY_BCAST};

  always_ff @(posedge mgmt_clk)
  begin
    if (!mrst_b)
    begin
      m_state_q   <= pcd_pkg::M_PRE;
      ones_q      <= 6'h00;
      bit_cnt_q   <= 5'h00;
      hdr_q       <= 11'h000;
      shift_q     <= 16'h0000;
      is_read_q   <= 1'b0;
      req_tgl_q   <= 1'b0;
      req_addr_q  <= 5'h00;
      req_we_q    <= 1'b0;
      req_wdata_q <= 16'h0000;
      mdio_out    <= 1'b0;
      mdio_oe     <= 1'b0;
    end
    else
    begin
      case (m_state_q)
        pcd_pkg::M_PRE:
        begin
          mdio_oe <= 1'b0;
          if (mdio_in)
            ones_q <= (ones_q == pcd_pkg::PRE_ONES) ? ones_q : ones_q + 6'h01;
          else
          begin
            ones_q <= 6'h00;
            if (ones_q == pcd_pkg::PRE_ONES)
              m_state_q <= pcd_pkg::M_START;
          end
        end
        pcd_pkg::M_START:
        begin
          bit_cnt_q <= 5'h00;
          m_state_q <= mdio_in ? pcd_pkg::M_HDR : pcd_pkg::M_PRE;
        end
        pcd_pkg::M_HDR:
        begin
          hdr_q     <= {hdr_q[9:0], mdio_in};
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == {1'b0, pcd_pkg::HDR_BITS} - 5'h01)
          begin
            bit_cnt_q <= 5'h00;
            // 5-bit device and register addresses, opcode first
            req_addr_q <= {hdr_q[3:0], mdio_in};
            is_read_q  <= hdr_q[10:9] == pcd_pkg::OP_READ;
            if (!hdr_match || (hdr_q[10:9] != pcd_pkg::OP_READ && hdr_q[10:9] != pcd_pkg::OP_WRITE))
              m_state_q <= pcd_pkg::M_PRE;
            else
            begin
              m_state_q <= pcd_pkg::M_TA;
              if (hdr_q[10:9] == pcd_pkg::OP_READ)
              begin
                req_we_q  <= 1'b0;
                req_tgl_q <= ~req_tgl_q;
              end
            end
          end
        end
        pcd_pkg::M_TA:
        begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == 5'h00)
          begin
            // Second turnaround bit is driven low by us on reads
            mdio_oe  <= is_read_q;
            mdio_out <= 1'b0;
          end
          else
          begin
            bit_cnt_q <= 5'h00;
            m_state_q <= pcd_pkg::M_DATA;
            // Read word has been stable for a whole bit time by now
            shift_q   <= {rdata_q[14:0], 1'b0};
            mdio_out  <= rdata_q[15];
          end
        end
        pcd_pkg::M_DATA:
        begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          if (is_read_q)
          begin
            mdio_out <= shift_q[15];
            shift_q  <= {shift_q[14:0], 1'b0};
          end
          else
            shift_q <= {shift_q[14:0], mdio_in};
          if (bit_cnt_q == pcd_pkg::DATA_BITS - 5'h01)
          begin
            m_state_q <= pcd_pkg::M_PRE;
            mdio_oe   <= 1'b0;
            ones_q    <= 6'h00;
            if (!is_read_q)
            begin
              req_wdata_q <= {shift_q[14:0], mdio_in};
              req_we_q    <= 1'b1;
              req_tgl_q   <= ~req_tgl_q;
            end
          end
        end
        default:
          m_state_q <= pcd_pkg::M_PRE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Request crossing into the reference clock domain
  // ----------------------------------------------------------------------------
  logic [2:0]  req_sync_q;
  logic        req_pulse;
  logic        rd_pulse;
  logic        wr_pulse;

  // Address, direction and write data are held still until the next frame's header is received
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      req_sync_q <= 3'h0;
    else
      req_sync_q <= {req_sync_q[1:0], req_tgl_q};
  end
  assign req_pulse = req_sync_q[2] ^ req_sync_q[1];
  assign rd_pulse  = req_pulse & ~req_we_q;
  assign wr_pulse  = req_pulse & req_we_q;

  // ----------------------------------------------------------------------------
  // Input synchronisers for pin-level signals
  // ----------------------------------------------------------------------------
  logic [1:0]  mdi_sync_q;
  logic [1:0]  lnk_sync_q;
  logic [1:0]  strap_sync_q;
  logic [18:0] pad_s1_q;
  logic [18:0] pad_s2_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mdi_sync_q   <= 2'h0;
      lnk_sync_q   <= 2'h0;
      pad_s1_q     <= 19'h7FFFF;
      pad_s2_q     <= 19'h7FFFF;
    end
    else
    begin
      mdi_sync_q   <= {mdi_sync_q[0], partner_is_mdi};
      lnk_sync_q   <= {lnk_sync_q[0], link_100_full};
      pad_s1_q     <= chain_pad_in;
      pad_s2_q     <= pad_s1_q;
    end
  end

  // Strap keeps being sampled through reset so it is settled when reset ends
  always_ff @(posedge clk)
  begin
    strap_sync_q <= {strap_sync_q[0], chain_strap_b};
  end

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  logic [15:0] basic_q;
  logic [15:0] special_q;
  logic [7:0]  irq_en_q;
  logic [7:0]  irq_flags_q;
  logic [15:0] ctrl2_q;
  logic        ct_busy_q;
  logic [1:0]  ct_result_q;
  logic [8:0]  ct_dist_q;
  logic        ct_done;
  logic [15:0] rd_word;

  always_comb
  begin
    case (req_addr_q)
      pcd_pkg::REG_BASIC:   rd_word = basic_q;
      pcd_pkg::REG_SPECIAL: rd_word = special_q;
      pcd_pkg::REG_IRQ:     rd_word = {irq_en_q, irq_flags_q};
      pcd_pkg::REG_CABLE:   rd_word = {ct_busy_q, ct_result_q, 4'h0, ct_dist_q};
      pcd_pkg::REG_CTRL2:   rd_word = ctrl2_q;
      default:              rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_q <= 16'h0000;
    else if (rd_pulse)
      rdata_q <= rd_word;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      basic_q   <= pcd_pkg::BASIC_RST;
      special_q <= pcd_pkg::SPECIAL_RST;
      irq_en_q  <= pcd_pkg::IRQ_EN_RST;
      ctrl2_q   <= pcd_pkg::CTRL2_RST;
    end
    else if (wr_pulse)
    begin
      case (req_addr_q)
        pcd_pkg::REG_BASIC:   basic_q   <= req_wdata_q;
        pcd_pkg::REG_SPECIAL: special_q <= req_wdata_q;
        pcd_pkg::REG_IRQ:     irq_en_q  <= req_wdata_q[15:8];
        pcd_pkg::REG_CTRL2:   ctrl2_q   <= req_wdata_q;
        default:              basic_q   <= basic_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt flags and output
  // ----------------------------------------------------------------------------
  logic irq_active;

  // A new event in the clearing cycle survives the read
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_flags_q <= 8'h00;
    else if (rd_pulse && req_addr_q == pcd_pkg::REG_IRQ)
      irq_flags_q <= irq_events;
    else
      irq_flags_q <= irq_flags_q | irq_events;
  end

  assign irq_active = |(irq_flags_q & irq_en_q);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_out <= 1'b1;
    else
      irq_out <= ctrl2_q[pcd_pkg::C2_IRQ_POL] ? irq_active : ~irq_active;
  end

  // ----------------------------------------------------------------------------
  // Crossover and loopback controls
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mdix_sel    <= 1'b0;
      local_loop  <= 1'b0;
      remote_loop <= 1'b0;
      speed_100   <= 1'b0;
      aneg_en     <= 1'b0;
      full_duplex <= 1'b0;
    end
    else
    begin
      // A partner using MDI pairs needs us on MDI-X, and the other way round
      if (!ctrl2_q[pcd_pkg::C2_AUTOX_DIS])
        mdix_sel <= mdi_sync_q[1];
      else
        mdix_sel <= ~ctrl2_q[pcd_pkg::C2_PAIR_FORCE];
      local_loop  <= basic_q[pcd_pkg::BC_LOCAL_LOOP];
      speed_100   <= basic_q[pcd_pkg::BC_SPEED_100];
      aneg_en     <= basic_q[pcd_pkg::BC_ANEG_EN];
      full_duplex <= basic_q[pcd_pkg::BC_FULL_DUPLEX];
      // Remote wrap is held off unless the link really runs 100 full duplex
      remote_loop <= ctrl2_q[pcd_pkg::C2_REMOTE_LOOP] & lnk_sync_q[1];
    end
  end

  // ----------------------------------------------------------------------------
  // Cable test sequencer
  // ----------------------------------------------------------------------------
  pcd_pkg::pcd_cable_e c_state_q;
  logic [11:0]         quiet_cnt_q;

  assign ct_done = (c_state_q == pcd_pkg::C_MEAS && tdr_done)
                || (c_state_q == pcd_pkg::C_QUIET && !partner_quiet
                    && quiet_cnt_q == pcd_pkg::QUIET_WAIT_CYC - 12'h001);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      c_state_q   <= pcd_pkg::C_IDLE;
      quiet_cnt_q <= 12'h000;
      ct_busy_q   <= 1'b0;
      ct_result_q <= pcd_pkg::CT_NORMAL;
      ct_dist_q   <= 9'h000;
      tdr_start   <= 1'b0;
    end
    else
    begin
      tdr_start <= 1'b0;
      case (c_state_q)
        pcd_pkg::C_IDLE:
          if (wr_pulse && req_addr_q == pcd_pkg::REG_CABLE && req_wdata_q[pcd_pkg::CT_START])
          begin
            ct_busy_q   <= 1'b1;
            quiet_cnt_q <= 12'h000;
            c_state_q   <= pcd_pkg::C_QUIET;
          end
        pcd_pkg::C_QUIET:
          if (partner_quiet)
          begin
            tdr_start <= 1'b1;
            c_state_q <= pcd_pkg::C_MEAS;
          end
          else if (ct_done)
          begin
            // Partner would not go silent: no measurement is made
            ct_result_q <= pcd_pkg::CT_INVALID;
            ct_dist_q   <= 9'h000;
            ct_busy_q   <= 1'b0;
            c_state_q   <= pcd_pkg::C_IDLE;
          end
          else
            quiet_cnt_q <= quiet_cnt_q + 12'h001;
        pcd_pkg::C_MEAS:
          if (ct_done)
          begin
            ct_result_q <= tdr_result;
            ct_dist_q   <= tdr_dist;
            ct_busy_q   <= 1'b0;
            c_state_q   <= pcd_pkg::C_IDLE;
          end
        default:
          c_state_q <= pcd_pkg::C_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Chain test
  // ----------------------------------------------------------------------------
  logic        strap_seen_q;
  logic        strap_chain_q;
  logic [18:0] nand_chain;
  logic        chain_mode;

  // Strap is captured once, on the first edge after reset is released
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      strap_seen_q  <= 1'b0;
      strap_chain_q <= 1'b0;
    end
    else if (!strap_seen_q)
    begin
      strap_seen_q  <= 1'b1;
      strap_chain_q <= ~strap_sync_q[1];
    end
  end

  assign chain_mode = strap_chain_q | special_q[pcd_pkg::SC_CHAIN_TEST];

  // Bit 0 is MDIO and bit 18 is COL, matching the board's lowering order
  genvar gi;
  generate
    for (gi = 0; gi < pcd_pkg::CHAIN_LEN; gi++)
    begin : g_nand
      if (gi == 0)
      begin : g_first
        assign nand_chain[gi] = ~pad_s2_q[gi];
      end
      else
      begin : g_next
        assign nand_chain[gi] = ~(pad_s2_q[gi] & nand_chain[gi-1]);
      end
    end
  endgenerate

  // Inverted end of an odd-length chain: high with all inputs high, then alternates
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      crs_out <= 1'b0;
    else
      crs_out <= chain_mode ? ~nand_chain[pcd_pkg::CHAIN_LEN-1] : crs_core;
  end

endmodule : pcd_top

// [verification/pcd_monitor.sv]
// Port checker of the PHY control and diagnostics block
`timescale 1ns/10ps
module pcd_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mgmt_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic irq_out,
  input wire logic link_100_full,
  input wire logic remote_loop,
  input wire logic local_loop,
  input wire logic mdix_sel,
  input wire logic tdr_start,
  input wire logic partner_quiet,
  input wire logic crs_out
);
  // ------
  // Helpers
  // ------
  logic [4:0] oe_cnt_q;

  // Edges the device holds the data line in one read
  always_ff @(posedge mgmt_clk)
  begin
    oe_cnt_q <= mdio_oe ? oe_cnt_q + 5'h01 : 5'h00;
  end

  sequence s_quiet_outs;
    irq_out && !tdr_start && !local_loop && !remote_loop && !mdix_sel && !crs_out;
  endsequence

  sequence s_turn_zero;
    mdio_oe && !mdio_out;
  endsequence

  // ------
  // Assertions
  // ------
  a_reset_quiet: assert property (@(posedge clk) !rst_b |=> s_quiet_outs)
    else $error("outputs not quiet in reset");
  a_irq_release: assert property (@(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> irq_out ##1 irq_out)
    else $error("interrupt active after reset");
  a_start_pulse: assert property (@(posedge clk) disable iff (!rst_b) tdr_start |=> !tdr_start [*8])
    else $error("measurement start repeated");
  a_start_quiet: assert property (@(posedge clk) disable iff (!rst_b) tdr_start |-> $past(partner_quiet))
    else $error("measurement started on a live partner");
  a_remote_link: assert property (@(posedge clk) disable iff (!rst_b) !link_100_full [*6] |-> !remote_loop)
    else $error("remote loop without fast full duplex link");
  a_mdio_reset: assert property (@(posedge mgmt_clk) !rst_b [*3] |=> !mdio_oe && !mdio_out)
    else $error("data line driven in reset");
  a_turn_zero: assert property (@(posedge mgmt_clk) disable iff (!rst_b) $rose(mdio_oe) |-> s_turn_zero)
    else $error("turnaround bit not zero");
  a_read_length: assert property (@(posedge mgmt_clk) disable iff (!rst_b) $fell(mdio_oe) |-> oe_cnt_q == 5'h11)
    else $error("read drive length wrong");
endmodule : pcd_monitor

bind pcd_top pcd_monitor i_mon (.clk, .rst_b, .mgmt_clk, .mdio_out, .mdio_oe, .irq_out, .link_100_full,
  .remote_loop, .local_loop, .mdix_sel, .tdr_start, .partner_quiet, .crs_out);

// [verification/pcd_mac_model.sv]
// Management controller model that clocks frames onto the data line
`timescale 1ns/10ps
module pcd_mac_model (
  output logic      mdc,
  output logic      drv_out,
  output logic      drv_oe,
  input  wire logic line
);
  // Clock stands still between frames, as the controller owns it
  initial
  begin
    mdc = 1'b0;
    drv_out = 1'b0;
    drv_oe = 1'b0;
  end

  // Drive after the low edge, sample just before the rise
  task automatic tick(input logic oe, input logic v, output logic smp);
    drv_oe = oe;
    drv_out = v;
    #80;
    smp = line;
    mdc = 1'b1;
    #80;
    mdc = 1'b0;
  endtask : tick

  task automatic head(input logic [1:0] op, input logic [4:0] ra);
    logic [11:0] h;
    logic        smp;
    h = {op, 5'h01, ra};
    repeat (32) tick(1'b1, 1'b1, smp);
    tick(1'b1, 1'b0, smp);
    tick(1'b1, 1'b1, smp);
    for (int i = 11; i >= 0; i--) tick(1'b1, h[i], smp);
  endtask : head

  task automatic wr(input logic [4:0] ra, input logic [15:0] dat);
    logic [17:0] w;
    logic        smp;
    w = {2'b10, dat};
    head(pcd_pkg::OP_WRITE, ra);
    for (int i = 17; i >= 0; i--) tick(1'b1, w[i], smp);
    drv_oe = 1'b0;
  endtask : wr

  // Last idle period lets the device release the line
  task automatic rd(input logic [4:0] ra, output logic [15:0] dat);
    logic smp;
    head(pcd_pkg::OP_READ, ra);
    repeat (2) tick(1'b0, 1'b0, smp);
    for (int i = 15; i >= 0; i--) tick(1'b0, 1'b0, dat[i]);
    tick(1'b0, 1'b0, smp);
  endtask : rd
endmodule : pcd_mac_model

// [verification/tb_top.sv]
// Self-checking testbench of the PHY control and diagnostics block
`timescale 1ns/10ps
module tb_top;
  // ------
  // Signals
  // ------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        mgmt_clk, mdio_out, mdio_oe, drv_out, drv_oe, s;
  logic        irq_out, mdix_sel, local_loop, remote_loop, speed_100;
  logic        aneg_en, full_duplex, tdr_start, crs_out;
  logic        partner_is_mdi = 1'b0;
  logic        link_100_full = 1'b0;
  logic        partner_quiet = 1'b0;
  logic        tdr_done = 1'b0;
  logic        crs_core = 1'b1;
  logic        strap_b = 1'b1;
  logic [7:0]  irq_events = 8'h00;
  logic [1:0]  tdr_result = 2'h0;
  logic [8:0]  tdr_dist = 9'h000;
  logic [18:0] chain_pad_in = 19'h7FFFF;
  logic [15:0] d;
  int          err_total = 0;
  int          num_checks = 0;
  int          starts = 0;
  // Data line has a pull-up, so a released line reads one
  wire         mdio_line = mdio_oe ? mdio_out : (drv_oe ? drv_out : 1'b1);

  pcd_top i_dut (.clk, .rst_b, .mgmt_clk, .mdio_in(mdio_line), .mdio_out, .mdio_oe, .irq_events, .irq_out,
    .partner_is_mdi, .mdix_sel, .link_100_full, .local_loop, .remote_loop, .speed_100, .aneg_en, .full_duplex,
    .tdr_start, .partner_quiet, .tdr_done, .tdr_result, .tdr_dist, .chain_strap_b(strap_b), .chain_pad_in,
    .crs_core, .crs_out);
  pcd_mac_model i_mac (.mdc(mgmt_clk), .drv_out, .drv_oe, .line(mdio_line));

  always #2 clk = ~clk;
  always @(posedge clk) if (tdr_start === 1'b1) starts++;

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t mismatch got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic rchk(input logic [4:0] ra, input logic [15:0] exp);
    i_mac.rd(ra, d);
    chk(d, exp);
  endtask : rchk

  task automatic pulse(input logic [7:0] v);
    @(posedge clk) irq_events <= v;
    @(posedge clk) irq_events <= 8'h00;
    cyc(3);
  endtask : pulse

  task automatic poll(input logic [15:0] exp);
    d = 16'h8000;
    for (int n = 0; n < 4 && d[15] !== 1'b0; n++) i_mac.rd(pcd_pkg::REG_CABLE, d);
    chk(d, exp);
  endtask : poll

  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    rchk(pcd_pkg::REG_BASIC, 16'h0000);
    rchk(pcd_pkg::REG_CTRL2, 16'h0000);
    rchk(pcd_pkg::REG_IRQ, 16'h0000);
    i_mac.wr(5'h05, 16'hFFFF);
    rchk(5'h05, 16'h0000);
  endtask : t_regs

  task automatic t_xover;
    @(posedge clk) partner_is_mdi <= 1'b1;
    cyc(5);
    chk(16'(mdix_sel), 16'h0001);
    i_mac.wr(pcd_pkg::REG_CTRL2, 16'h6000);
    chk(16'(mdix_sel), 16'h0000);
    @(posedge clk) partner_is_mdi <= 1'b0;
    i_mac.wr(pcd_pkg::REG_CTRL2, 16'h2000);
    chk(16'(mdix_sel), 16'h0001);
    i_mac.wr(pcd_pkg::REG_CTRL2, 16'h0000);
    chk(16'(mdix_sel), 16'h0000);
  endtask : t_xover

  task automatic t_irq;
    i_mac.wr(pcd_pkg::REG_IRQ, 16'h0100);
    pulse(8'h02);
    chk(16'(irq_out), 16'h0001);
    pulse(8'h01);
    chk(16'(irq_out), 16'h0000);
    rchk(pcd_pkg::REG_IRQ, 16'h0103);
    chk(16'(irq_out), 16'h0001);
    rchk(pcd_pkg::REG_IRQ, 16'h0100);
    i_mac.wr(pcd_pkg::REG_CTRL2, 16'h0200);
    chk(16'(irq_out), 16'h0000);
    pulse(8'h01);
    chk(16'(irq_out), 16'h0001);
    rchk(pcd_pkg::REG_IRQ, 16'h0101);
  endtask : t_irq

  task automatic t_loop;
    i_mac.wr(pcd_pkg::REG_BASIC, 16'h6100);
    chk(16'({local_loop, speed_100, aneg_en, full_duplex}), 16'h000D);
    i_mac.wr(pcd_pkg::REG_BASIC, 16'h4100);
    chk(16'({local_loop, speed_100, aneg_en, full_duplex}), 16'h0009);
    i_mac.wr(pcd_pkg::REG_CTRL2, 16'h0004);
    chk(16'(remote_loop), 16'h0000);
    @(posedge clk) link_100_full <= 1'b1;
    cyc(6);
    chk(16'(remote_loop), 16'h0001);
    @(posedge clk) link_100_full <= 1'b0;
  endtask : t_loop

  task automatic t_cable;
    i_mac.wr(pcd_pkg::REG_CTRL2, 16'h6000);
    @(posedge clk) partner_quiet <= 1'b1;
    for (int r = 0; r < 3; r++)
    begin
      i_mac.wr(pcd_pkg::REG_CABLE, 16'h8000);
      i_mac.rd(pcd_pkg::REG_CABLE, d);
      chk(16'(d[15]), 16'h0001);
      chk(16'(starts), 16'(r + 1));
      @(posedge clk)
      begin
        tdr_done <= 1'b1;
        tdr_result <= 2'(r);
        tdr_dist <= 9'h1FF >> r;
      end
      @(posedge clk) tdr_done <= 1'b0;
      poll({1'b0, 2'(r), 4'h0, 9'h1FF >> r});
    end
    @(posedge clk) partner_quiet <= 1'b0;
    i_mac.wr(pcd_pkg::REG_CABLE, 16'h8000);
    poll(16'h6000);
    chk(16'(starts), 16'h0003);
  endtask : t_cable

  task automatic t_chain;
    @(posedge clk) crs_core <= 1'b0;
    cyc(4);
    chk(16'(crs_out), 16'h0000);
    i_mac.wr(pcd_pkg::REG_SPECIAL, 16'h0020);
    chk(16'(crs_out), 16'h0001);
    for (int i = 0; i < 19; i++)
    begin
      @(posedge clk) chain_pad_in[i] <= 1'b0;
      cyc(4);
      chk(16'(crs_out), 16'(i[0]));
    end
  endtask : t_chain

  // Mid-run reset with the strap low enters chain test without the register bit
  task automatic t_strap;
    @(posedge clk)
    begin
      rst_b        <= 1'b0;
      strap_b      <= 1'b0;
      chain_pad_in <= 19'h7FFFF;
    end
    cyc(8);
    @(posedge clk) rst_b <= 1'b1;
    cyc(4);
    chk(16'(crs_out), 16'h0001);
    @(posedge clk) chain_pad_in[0] <= 1'b0;
    cyc(4);
    chk(16'(crs_out), 16'h0000);
  endtask : t_strap

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // Management domain needs its own edges while reset is low
  initial
  begin
    repeat (4) i_mac.tick(1'b0, 1'b0, s);
    repeat (8) @(posedge clk);
    @(posedge clk) rst_b <= 1'b1;
    // Two idle edges let the management domain leave reset before a preamble
    repeat (2) i_mac.tick(1'b0, 1'b0, s);
    t_regs;
    t_xover;
    t_irq;
    t_loop;
    t_cable;
    t_chain;
    t_strap;
    test_done;
  end

  initial
  begin
    #390000;
    err_total++;
    test_done;
  end
endmodule : tb_top
